// File: verilog/cml_consts.svh
// offsets, field positions and reset values of the charge control register bank
`ifndef CML_CONSTS_SVH
`define CML_CONSTS_SVH

`define CML_OFF_KEY 8'h00
`define CML_OFF_DAC_LEVEL 8'h04
`define CML_OFF_DAC_CTRL 8'h08
`define CML_OFF_SENSE_SEL 8'h0C
`define CML_OFF_AMP_OFS 8'h10
`define CML_OFF_SUPPLY 8'h14
`define CML_OFF_IRQ_STAT 8'h18
`define CML_OFF_IRQ_MASK 8'h1C

`define CML_KEY_PATTERN 8'hAA
`define CML_KEY_RESET 8'h00
`define CML_DAC_LEVEL_RESET 8'h80
`define CML_DAC_EN_RESET 1'h1
`define CML_SENSE_SEL_RESET 6'h15
`define CML_CODE_CH0 6'h15
`define CML_CODE_CH1 6'h2A
`define CML_AMP_TRIM_RESET 5'h00
`define CML_IRQ_RESET 2'h0

`define CML_BIT_DAC_EN 7
`define CML_BIT_CAL_MODE 7
`define CML_BIT_REF_SEL 6
`define CML_BIT_AMP_OUT 5
`define CML_BIT_SUPPLY 0
`define CML_BIT_IRQ_OV 0
`define CML_BIT_IRQ_OC 1

`define CML_RESP_OKAY 2'h0
`define CML_RESP_SLVERR 2'h2

`endif

// File: verilog/cml_pkg.sv
// types shared by the charge control register bank
package cml_pkg;

    // analog comparator levels arriving from outside the clock domain
    typedef struct packed {
        logic amp_out;
        logic supply_good;
        logic over_current_cmp;
        logic over_voltage_cmp;
    } cml_sense_t;

    typedef enum logic {
        CML_CH0 = 1'b0,
        CML_CH1 = 1'b1
    } cml_chan_t;

endpackage

// File: verilog/cml_sync.sv
// three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module cml_sync #(
    parameter int WIDTH = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                    stage3[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    // a lone differing sample is treated as a glitch
                    if (stage2[i] == stage3[i]) begin
                        sync_out[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule // cml_sync

`default_nettype wire

// File: verilog/cml_top.sv
// charge module control: key lock, protection detect, interrupt and AXI4-Lite slave
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cml_consts.svh"

// Notes on behaviour
// [R1] The 8-bit key register resets to zero and protected writes land only while it holds AA.
// [R2] With any other key, writes to the DAC level, DAC control, sense select and amp offset drop.
// [R3] Over-current detect rises when the current comparator and supply-good are both high.
// [R4] Over-voltage detect rises when the voltage comparator and supply-good are both high.
// [R5] The shared protection interrupt reaches the output only where its enable bit is set.
// [R6] Channel 0 routes the voltage sense out, channel 1 routes the amplified current voltage.
// [R7] Code 010101 selects channel 0, code 101010 channel 1, any other code keeps the switch.
// [R8] The DAC enable bit powers the DAC and closes its switch, and it resets to one.
// [R9] The calibration bit picks normal or offset mode, and the amp output reads back read-only.
// [R10] A read-only supply-good flag shows the supply detector and resets to zero.
// [R11] Protected registers always read back, and the key register is always writable.
module cml_top (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cml_pkg::cml_sense_t sense_in,
    output logic [7:0] dac_level,
    output logic dac_power_enable,
    output cml_pkg::cml_chan_t mux_channel,
    output logic amp_calibration_mode,
    output logic amp_ref_select,
    output logic [4:0] amp_offset_trim,
    output logic over_voltage_detect,
    output logic over_current_detect,
    output logic error_amp_force_low,
    output logic protection_irq
);
    cml_pkg::cml_sense_t sense_sync;
    logic [7:0] unlock_key_bits;
    logic [5:0] channel_select_code;
    logic supply_good_flag;
    logic amp_output_state;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] wr_addr;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    cml_sync #(
        .WIDTH($bits(cml_pkg::cml_sense_t))
    ) i_cml_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(sense_in),
        .sync_out(sense_sync)
    );

    // write channel: address and data latched independently, then one write
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_lane = wr_fire && wstrb_q[0];
    wire unlocked = unlock_key_bits == `CML_KEY_PATTERN;
    wire wr_prot = wr_lane && unlocked;
    wire wr_key = wr_lane && wr_addr == `CML_OFF_KEY;
    wire wr_dac_level = wr_prot && wr_addr == `CML_OFF_DAC_LEVEL;
    wire wr_dac_ctrl = wr_prot && wr_addr == `CML_OFF_DAC_CTRL;
    wire wr_sense = wr_prot && wr_addr == `CML_OFF_SENSE_SEL;
    wire wr_amp = wr_prot && wr_addr == `CML_OFF_AMP_OFS;
    wire wr_mask = wr_lane && wr_addr == `CML_OFF_IRQ_MASK;
    wire wr_mapped = wr_addr[7:5] == 3'h0 && wr_addr[1:0] == 2'h0;
    wire [5:0] code_in = wdata_q[5:0];

    // read channel
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_mapped = s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0;
    wire rd_stat = ar_take && s_axi_araddr == `CML_OFF_IRQ_STAT;
    wire [7:0] amp_read = {amp_calibration_mode, amp_ref_select, amp_output_state,
                           amp_offset_trim};
    wire [7:0] rd_byte =
        s_axi_araddr == `CML_OFF_KEY ? unlock_key_bits :
        s_axi_araddr == `CML_OFF_DAC_LEVEL ? dac_level :
        s_axi_araddr == `CML_OFF_DAC_CTRL ? {dac_power_enable, 7'h00} :
        s_axi_araddr == `CML_OFF_SENSE_SEL ? {2'h0, channel_select_code} :
        s_axi_araddr == `CML_OFF_AMP_OFS ? amp_read :
        s_axi_araddr == `CML_OFF_SUPPLY ? {7'h00, supply_good_flag} :
        s_axi_araddr == `CML_OFF_IRQ_STAT ? {6'h00, irq_status} :
        s_axi_araddr == `CML_OFF_IRQ_MASK ? {6'h00, irq_mask} : 8'h00; // [R11]

    // protection: detect levels qualified by supply-good
    wire next_ov = sense_sync.over_voltage_cmp && sense_sync.supply_good; // [R4]
    wire next_oc = sense_sync.over_current_cmp && sense_sync.supply_good; // [R3]
    wire [1:0] events = {next_oc, next_ov};
    // a read clears the flags, but an event in the same cycle still sets them
    wire [1:0] next_status = (rd_stat ? 2'h0 : irq_status) | events;
    wire [1:0] next_mask = wr_mask ? wdata_q[1:0] : irq_mask;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CML_RESP_OKAY;
            wr_addr <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                s_axi_awready <= 1'b0;
                wr_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                s_axi_awready <= 1'b1;
            end
            if (w_take) begin
                s_axi_wready <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `CML_RESP_OKAY : `CML_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CML_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_mapped ? `CML_RESP_OKAY : `CML_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            unlock_key_bits <= `CML_KEY_RESET;
            dac_level <= `CML_DAC_LEVEL_RESET;
            dac_power_enable <= `CML_DAC_EN_RESET;
            channel_select_code <= `CML_SENSE_SEL_RESET;
            mux_channel <= cml_pkg::CML_CH0;
        end else begin
            if (wr_key) begin
                unlock_key_bits <= wdata_q[7:0]; // [R11]
            end
            if (wr_dac_level) begin
                dac_level <= wdata_q[7:0]; // [R1] [R2]
            end
            if (wr_dac_ctrl) begin
                dac_power_enable <= wdata_q[`CML_BIT_DAC_EN]; // [R8]
            end
            if (wr_sense) begin
                channel_select_code <= code_in;
                if (code_in == `CML_CODE_CH0) begin
                    mux_channel <= cml_pkg::CML_CH0; // [R6] [R7]
                end else if (code_in == `CML_CODE_CH1) begin
                    mux_channel <= cml_pkg::CML_CH1; // [R6] [R7]
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            amp_calibration_mode <= 1'b0;
            amp_ref_select <= 1'b0;
            amp_offset_trim <= `CML_AMP_TRIM_RESET;
            amp_output_state <= 1'b0;
            supply_good_flag <= 1'b0;
        end else begin
            if (wr_amp) begin
                amp_calibration_mode <= wdata_q[`CML_BIT_CAL_MODE]; // [R9]
                amp_ref_select <= wdata_q[`CML_BIT_REF_SEL];
                amp_offset_trim <= wdata_q[4:0];
            end
            amp_output_state <= sense_sync.amp_out; // [R9]
            supply_good_flag <= sense_sync.supply_good; // [R10]
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            over_voltage_detect <= 1'b0;
            over_current_detect <= 1'b0;
            error_amp_force_low <= 1'b0;
            irq_status <= `CML_IRQ_RESET;
            irq_mask <= `CML_IRQ_RESET;
            protection_irq <= 1'b0;
        end else begin
            over_voltage_detect <= next_ov; // [R4]
            over_current_detect <= next_oc; // [R3]
            error_amp_force_low <= next_ov || next_oc; // [R3] [R4]
            irq_status <= next_status;
            irq_mask <= next_mask;
            protection_irq <= |(next_status & next_mask); // [R5]
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence locked_write(logic [7:0] off);
        wr_lane && !unlocked && wr_addr == off;
    endsequence

    sequence open_write(logic [7:0] off);
        wr_lane && unlocked && wr_addr == off;
    endsequence

    locked_level_a: assert property (locked_write(`CML_OFF_DAC_LEVEL) |=> $stable(dac_level)) // [R2]
        else $error("dac level changed while locked");
    locked_amp_a: assert property (locked_write(`CML_OFF_AMP_OFS)
        |=> $stable(amp_offset_trim) && $stable(amp_calibration_mode)) // [R2]
        else $error("amp offset changed while locked");
    open_level_a: assert property (open_write(`CML_OFF_DAC_LEVEL)
        |=> dac_level == $past(wdata_q[7:0])) // [R1]
        else $error("unlocked dac level write lost");
    key_write_a: assert property (wr_key |=> unlock_key_bits == $past(wdata_q[7:0])) // [R11]
        else $error("key write lost");
    ov_detect_a: assert property (sense_sync.over_voltage_cmp && sense_sync.supply_good
        |=> over_voltage_detect && error_amp_force_low) // [R4]
        else $error("over-voltage not detected");
    oc_supply_a: assert property (!sense_sync.supply_good |=> !over_current_detect
        && !over_voltage_detect) // [R3]
        else $error("detect without supply good");
    oc_force_a: assert property (over_current_detect |-> error_amp_force_low) // [R3]
        else $error("over-current did not force amp low");
    irq_gate_a: assert property (protection_irq == |(irq_status & irq_mask)) // [R5]
        else $error("interrupt not gated by mask");
    mux_select_a: assert property (open_write(`CML_OFF_SENSE_SEL) ##0 code_in == `CML_CODE_CH1
        |=> mux_channel == cml_pkg::CML_CH1) // [R6] [R7]
        else $error("channel 1 code not applied");
    mux_keep_a: assert property (open_write(`CML_OFF_SENSE_SEL)
        ##0 (code_in != `CML_CODE_CH0 && code_in != `CML_CODE_CH1)
        |=> $stable(mux_channel)) // [R7]
        else $error("other code moved the switch");
    dac_enable_a: assert property (open_write(`CML_OFF_DAC_CTRL)
        |=> dac_power_enable == $past(wdata_q[7])) // [R8]
        else $error("dac enable write lost");
    supply_flag_a: assert property ($rose(sense_sync.supply_good) |=> supply_good_flag) // [R10]
        else $error("supply flag did not follow");
    cal_read_a: assert property (ar_take && s_axi_araddr == `CML_OFF_AMP_OFS
        |=> s_axi_rdata[5] == $past(amp_output_state)
        && s_axi_rdata[7] == $past(amp_calibration_mode)) // [R9]
        else $error("amp offset readback wrong");

    // the remaining protected registers, the detect checks, and the gating and status of the shared interrupt
    locked_ctrl_a: assert property (locked_write(`CML_OFF_DAC_CTRL)
        |=> $stable(dac_power_enable)) // [R2]
        else $error("dac enable changed while locked");
    locked_sense_a: assert property (locked_write(`CML_OFF_SENSE_SEL)
        |=> $stable(channel_select_code) && $stable(mux_channel)) // [R2]
        else $error("sense select changed while locked");
    open_amp_a: assert property (open_write(`CML_OFF_AMP_OFS)
        |=> amp_offset_trim == $past(wdata_q[4:0])
        && amp_calibration_mode == $past(wdata_q[`CML_BIT_CAL_MODE])) // [R9]
        else $error("unlocked amp offset write lost");
    mux_zero_a: assert property (open_write(`CML_OFF_SENSE_SEL) ##0 code_in == `CML_CODE_CH0
        |=> mux_channel == cml_pkg::CML_CH0) // [R6] [R7]
        else $error("channel 0 code not applied");
    oc_detect_a: assert property (sense_sync.over_current_cmp && sense_sync.supply_good
        |=> over_current_detect && error_amp_force_low) // [R3]
        else $error("over-current not detected");
    ov_force_a: assert property (over_voltage_detect |-> error_amp_force_low) // [R4]
        else $error("over-voltage did not force amp low");
    irq_quiet_a: assert property (irq_mask == 2'h0 && !wr_mask |=> !protection_irq) // [R5]
        else $error("interrupt raised while all masked");
    irq_raise_a: assert property (next_ov && irq_mask[`CML_BIT_IRQ_OV] && !wr_mask
        |=> protection_irq) // [R5]
        else $error("enabled over-voltage did not interrupt");
    stat_sticky_a: assert property (irq_status[`CML_BIT_IRQ_OV] && !rd_stat
        |=> irq_status[`CML_BIT_IRQ_OV]) // [R5]
        else $error("over-voltage status dropped without a read");
    stat_clear_a: assert property (rd_stat && !next_ov && !next_oc
        |=> irq_status == 2'h0) // [R5]
        else $error("status not cleared by read");
endmodule // cml_top

`default_nettype wire

// File: verif/cml_pwm_model.sv
// behavioural analog front end and the pwm controller behind the photo-coupler
`timescale 1ns/1ps
`default_nettype none

module cml_pwm_model (
    input wire logic mclk,
    input wire logic vsense_high,
    input wire logic isense_high,
    input wire logic supply_ok,
    input wire logic amp_high,
    input wire logic error_amp_force_low,
    output cml_pkg::cml_sense_t sense_in,
    output logic duty_raise
);
    // comparator levels are async to mclk, as the real analog side is
    assign sense_in = {amp_high, supply_ok, isense_high, vsense_high};
    // duty may grow only while the coupler is not pulled low
    always_ff @(posedge mclk) duty_raise <= !error_amp_force_low;
endmodule // cml_pwm_model

`default_nettype wire

// File: verif/cml_top_tb.sv
// self-checking bench for the charge control register bank
`timescale 1ns/1ps
`default_nettype none
`include "cml_consts.svh"

module cml_top_tb;
    logic mclk = 0, resetn = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic vs = 0, is = 0, pg = 0, amp = 0;
    cml_pkg::cml_sense_t sense_in;
    cml_pkg::cml_chan_t mux_channel;
    logic [7:0] dac_level;
    logic [4:0] trim;
    logic dac_en, cal, refsel, ovd, ocd, force_low, irq, duty_raise;
    int err_count = 0, comparisons = 0;

    always #50 mclk = ~mclk;

    cml_top i_cml_top (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sense_in(sense_in), .dac_level(dac_level),
        .dac_power_enable(dac_en), .mux_channel(mux_channel), .amp_calibration_mode(cal),
        .amp_ref_select(refsel), .amp_offset_trim(trim), .over_voltage_detect(ovd),
        .over_current_detect(ocd), .error_amp_force_low(force_low), .protection_irq(irq));

    cml_pwm_model i_cml_pwm_model (.mclk(mclk), .vsense_high(vs), .isense_high(is),
        .supply_ok(pg), .amp_high(amp), .error_amp_force_low(force_low),
        .sense_in(sense_in), .duty_raise(duty_raise));

    task automatic end_sim();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // callers arrive mid-cycle, so the values handed in are the settled ones
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    // looks mid-cycle, acts on the next rising edge, which is where the slave samples
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] resp;
        tb = 1'b0;
        resp = 2'h0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge mclk);
            ta = awvalid && awready === 1'b1;
            tw = wvalid && wready === 1'b1;
            tb = bvalid === 1'b1;
            resp = bresp;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        @(negedge mclk);
        chk("bresp", er, resp);
    endtask

    // data and response are sampled mid-cycle, at the falling edge before the rising edge that completes the handshake
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] data;
        logic [1:0] resp;
        tr = 1'b0;
        data = 32'h0000_0000;
        resp = 2'h0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr) begin
            @(negedge mclk);
            ta = arvalid && arready === 1'b1;
            tr = rvalid === 1'b1;
            data = rdata;
            resp = rresp;
            @(posedge mclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        @(negedge mclk);
        chk("rdata", ed, data);
        chk("rresp", er, resp);
    endtask

    // pins move on a rising edge; sync, detect and status stages settle well inside ten cycles
    task automatic pins(input logic [3:0] s);
        @(posedge mclk);
        {amp, pg, is, vs} <= s;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic t_reset();
        rd(`CML_OFF_KEY, 32'h0, `CML_RESP_OKAY);
        rd(`CML_OFF_DAC_LEVEL, 32'h80, `CML_RESP_OKAY);
        rd(`CML_OFF_DAC_CTRL, 32'h80, `CML_RESP_OKAY);
        rd(`CML_OFF_SENSE_SEL, 32'h15, `CML_RESP_OKAY);
        rd(`CML_OFF_AMP_OFS, 32'h0, `CML_RESP_OKAY);
        rd(`CML_OFF_SUPPLY, 32'h0, `CML_RESP_OKAY);
        rd(`CML_OFF_IRQ_MASK, 32'h0, `CML_RESP_OKAY);
        chk("dac_en", 1, dac_en);
        chk("mux", cml_pkg::CML_CH0, mux_channel);
    endtask

    task automatic t_locked();
        wr(`CML_OFF_KEY, 32'hAB, `CML_RESP_OKAY);
        wr(`CML_OFF_DAC_LEVEL, 32'h33, `CML_RESP_OKAY);
        wr(`CML_OFF_DAC_CTRL, 32'h00, `CML_RESP_OKAY);
        wr(`CML_OFF_SENSE_SEL, 32'h2A, `CML_RESP_OKAY);
        wr(`CML_OFF_AMP_OFS, 32'h9F, `CML_RESP_OKAY);
        rd(`CML_OFF_KEY, 32'hAB, `CML_RESP_OKAY);
        rd(`CML_OFF_DAC_LEVEL, 32'h80, `CML_RESP_OKAY);
        rd(`CML_OFF_AMP_OFS, 32'h0, `CML_RESP_OKAY);
        chk("dac_level", 8'h80, dac_level);
        chk("dac_en", 1, dac_en);
        chk("mux", cml_pkg::CML_CH0, mux_channel);
    endtask

    task automatic t_unlocked();
        wr(`CML_OFF_KEY, 32'hAA, `CML_RESP_OKAY);
        wr(`CML_OFF_DAC_LEVEL, 32'h5A, `CML_RESP_OKAY);
        chk("dac_level", 8'h5A, dac_level);
        rd(`CML_OFF_DAC_LEVEL, 32'h5A, `CML_RESP_OKAY);
        wr(`CML_OFF_DAC_CTRL, 32'h00, `CML_RESP_OKAY);
        chk("dac_en", 0, dac_en);
        wr(`CML_OFF_DAC_CTRL, 32'h80, `CML_RESP_OKAY);
        chk("dac_en", 1, dac_en);
        wr(`CML_OFF_SENSE_SEL, 32'h2A, `CML_RESP_OKAY);
        chk("mux", cml_pkg::CML_CH1, mux_channel);
        wr(`CML_OFF_SENSE_SEL, 32'h3F, `CML_RESP_OKAY);
        chk("mux", cml_pkg::CML_CH1, mux_channel);
        wr(`CML_OFF_SENSE_SEL, 32'h15, `CML_RESP_OKAY);
        chk("mux", cml_pkg::CML_CH0, mux_channel);
        wr(`CML_OFF_AMP_OFS, 32'hFF, `CML_RESP_OKAY);
        chk("amp", 7'h7F, {cal, refsel, trim});
        rd(`CML_OFF_AMP_OFS, 32'hDF, `CML_RESP_OKAY);
        pins(4'h8);
        rd(`CML_OFF_AMP_OFS, 32'hFF, `CML_RESP_OKAY);
    endtask

    // pin order is amp output, supply good, current comparator, voltage comparator
    task automatic t_protect();
        pins(4'h9);
        chk("ovd", 0, {ovd, force_low});
        pins(4'hD);
        chk("ovd", 2'b11, {ovd, force_low});
        chk("irq", 0, irq);
        chk("duty", 0, duty_raise);
        rd(`CML_OFF_SUPPLY, 32'h1, `CML_RESP_OKAY);
        wr(`CML_OFF_IRQ_MASK, 32'h3, `CML_RESP_OKAY);
        chk("irq", 1, irq);
        pins(4'hC);
        chk("duty", 1, duty_raise);
        rd(`CML_OFF_IRQ_STAT, 32'h1, `CML_RESP_OKAY);
        chk("irq", 0, irq);
        pins(4'hE);
        chk("ocd", 3'b111, {ocd, force_low, irq});
        pins(4'hC);
        rd(`CML_OFF_IRQ_STAT, 32'h2, `CML_RESP_OKAY);
        chk("irq", 0, {irq, ocd, force_low});
    endtask

    // a reset in mid-run must relock the bank and bring back the reset level
    task automatic t_rereset();
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        rd(`CML_OFF_KEY, 32'h0, `CML_RESP_OKAY);
        wr(`CML_OFF_DAC_LEVEL, 32'h11, `CML_RESP_OKAY);
        rd(`CML_OFF_DAC_LEVEL, 32'h80, `CML_RESP_OKAY);
        chk("dac_en", 1, dac_en);
    endtask

    initial begin
        #3000000;
        err_count++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1;
        t_reset();
        t_locked();
        t_unlocked();
        t_protect();
        t_rereset();
        wr(8'h20, 32'h1, `CML_RESP_SLVERR);
        rd(8'h22, 32'h0, `CML_RESP_SLVERR);
        end_sim();
    end
endmodule // cml_top_tb

`default_nettype wire
